// ==== core/pcs_pkg.sv ====
// Constants shared by the configuration status word and its interrupt helper.
// Assumes one clock domain and configuration accesses of one 16-bit word.
package pcs_pkg;

	// ********************************************************
	// Offsets
	// ********************************************************
	localparam logic [7:0]  CMD_OFFSET    = 8'h04;
	localparam logic [7:0]  STATUS_OFFSET = 8'h06;

	// ********************************************************
	// Status word fields
	// ********************************************************
	localparam int          DET_PAR_BIT   = 15;
	localparam int          SIG_SERR_BIT  = 14;
	localparam int          RX_MABT_BIT   = 13;
	localparam int          RX_TABT_BIT   = 12;
	localparam int          SIG_TABT_BIT  = 11;
	localparam int          MST_DPAR_BIT  = 8;
	localparam int          INT_STAT_BIT  = 3;
	localparam int          DEVSEL_LSB    = 9;
	localparam logic [1:0]  DEVSEL_MEDIUM = 2'h1;
	localparam int          CAP_LIST_BIT  = 4;
	// Positions that write-one-to-clear touches.
	localparam logic [15:0] FLAG_MASK     = 16'hF900;
	// Constant part of the word: medium decode and capability list.
	localparam logic [15:0] CONST_BITS    = 16'h0210;
	localparam logic [15:0] STATUS_RESET  = 16'h0210;

	// ********************************************************
	// Command enable bits kept here
	// ********************************************************
	localparam int          INT_DIS_BIT   = 10;
	localparam int          SERR_EN_BIT   = 8;
	localparam int          PAR_RESP_BIT  = 6;
	localparam logic [15:0] CMD_WR_MASK   = 16'h0540;
	localparam logic [15:0] CMD_RESET     = 16'h0000;

	// ********************************************************
	// Interrupt sources
	// ********************************************************
	localparam int          INT_SOURCES   = 4;

endpackage

// ==== core/pcs_irq_if.sv ====
// Carrier between the status word core and its interrupt helper.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface pcs_irq_if;
	logic int_disable;
	logic int_pending;
	logic intx;

	modport gen (
		input  int_disable,
		output int_pending,
		output intx
	);
	modport core (
		output int_disable,
		input  int_pending,
		input  intx
	);
endinterface

// ==== core/pcs_irq_gen.sv ====
// Interrupt pending state and INTx drive for the status word.
// Assumes condition and enable inputs come from logic on the same clock.
`timescale 1ns/1ps
module pcs_irq_gen (
	// Clock and reset
	input  wire logic                             clock,
	input  wire logic                             arst_n,
	// Interrupt conditions and their signaling enables
	input  wire logic [pcs_pkg::INT_SOURCES-1:0] int_cond,
	input  wire logic [pcs_pkg::INT_SOURCES-1:0] int_cond_en,
	// Link to the core
	pcs_irq_if.gen                                irq
);

	logic int_pending_reg;
	logic int_pending_next;
	logic intx_reg;

	// A condition counts only while its signaling is enabled.
	assign int_pending_next = |(int_cond & int_cond_en); // R14

	// Pending mirror; the disable control never touches it.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			int_pending_reg <= 1'h0;
		end else begin
			int_pending_reg <= int_pending_next; // R12 R13
		end
	end

	// INTx follows the same next value so it lines up with the mirror bit.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			intx_reg <= 1'h0;
		end else begin
			intx_reg <= int_pending_next & ~irq.int_disable; // R12 R13
		end
	end

	assign irq.int_pending = int_pending_reg;
	assign irq.intx        = intx_reg;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);

	intx_gate_a: assert property (intx_reg |-> int_pending_reg && !$past(irq.int_disable)) // R12
		else $error("INTx asserted while disabled or nothing pending.");
	pend_unmasked_a: assert property ($past(int_pending_next) |-> int_pending_reg) // R13
		else $error("Pending bit lost while a condition was enabled.");
	pend_enabled_a: assert property (int_pending_reg |-> $past(|(int_cond & int_cond_en))) // R14
		else $error("Pending bit set without an enabled condition.");
	cover_masked_c: cover property (int_pending_reg && !intx_reg);

endmodule

// ==== core/pcs_status_word.sv ====
// Configuration status word of a card host function, with the command
// enable bits that gate it. Assumes event strobes are one-cycle pulses from
// bus logic on the same clock, and one configuration access per cycle.
// The command word keeps only the three enables that this word depends on;
// its other bits read zero, so software that expects a full command
// register must not rely on reading back what it wrote there.
//
// Overview of operation
// R01: Write one clears a flag; reads harmless.
// R02: Sixteen bits at 06h, reset 0210h.
// R03: Address or data parity error sets bit 15.
// R04: Enabled SERR assertion sets bit 14.
// R05: Own cycle master abort sets bit 13.
// R06: Own cycle target abort sets bit 12.
// R07: Issuing target abort sets bit 11.
// R08: Bits 10:9 constant 01b, medium decode.
// R09: Bit 8 needs PERR, mastership, enable.
// R10: Bits 7, 6, 5 read zero.
// R11: Bit 4 reads one.
// R12: Bit 3 mirrors pending; INTx gated.
// R13: Interrupt disable never masks bit 3.
// R14: Only enabled conditions raise bit 3.
// R15: Bits 2:0 read zero, ignore writes.
// R16: SERR undriven while command bit 8 clear; a request in the cycle that clears it still drives SERR one cycle.
// R17: Set beats clear in same cycle.
`timescale 1ns/1ps
module pcs_status_word (
	// Clock and reset
	input  wire logic                             clock,
	input  wire logic                             arst_n,
	// Configuration access port
	input  wire logic                             cfg_rd_en,
	input  wire logic                             cfg_wr_en,
	input  wire logic [7:0]                       cfg_offset,
	input  wire logic [1:0]                       cfg_byte_en,
	input  wire logic [15:0]                      cfg_wr_data,
	output logic      [15:0]                      cfg_rd_data,
	output logic                                  cfg_rd_valid,
	// Bus event strobes
	input  wire logic                             addr_parity_err,
	input  wire logic                             data_parity_err,
	input  wire logic                             serr_request,
	input  wire logic                             master_abort,
	input  wire logic                             target_abort_rcvd,
	input  wire logic                             target_abort_sent,
	input  wire logic                             perr_seen,
	input  wire logic                             master_data_phase,
	// Interrupt conditions
	input  wire logic [pcs_pkg::INT_SOURCES-1:0] int_cond,
	input  wire logic [pcs_pkg::INT_SOURCES-1:0] int_cond_en,
	// Bus signal drives
	output logic                                  serr_out,
	output logic                                  intx_out,
	output logic [1:0]                            devsel_timing
);

	// ********************************************************
	// Decode helpers
	// ********************************************************

	// Expands byte enables into a bit mask; used for both registers.
	function automatic logic [15:0] lane_mask(input logic [1:0] be);
		lane_mask = {{8{be[1]}}, {8{be[0]}}};
	endfunction

	// True when a write lands at the given word offset.
	function automatic logic hits(input logic en, input logic [7:0] off, input logic [7:0] target);
		hits = en && (off == target);
	endfunction

	// ********************************************************
	// Storage
	// ********************************************************
	logic [15:0] flags_reg;
	logic [15:0] flags_next;
	logic [15:0] flag_set;
	logic [15:0] flag_clr;
	logic [15:0] cmd_reg;
	logic [15:0] cmd_next;
	logic [15:0] status_view;
	logic [15:0] rd_data_reg;
	logic        rd_valid_reg;
	logic        serr_reg;
	logic        serr_fire;
	logic        detected_parity_flag;
	logic        signaled_system_error_flag;
	logic        received_master_abort_flag;
	logic        received_target_abort_flag;
	logic        signaled_target_abort_flag;
	logic        master_data_parity_flag;
	logic        system_error_enable;
	logic        parity_response_enable;
	logic [1:0]  devsel_reg;

	pcs_irq_if irq ();

	// ********************************************************
	// Command enables
	// ********************************************************

	assign system_error_enable    = cmd_reg[pcs_pkg::SERR_EN_BIT];
	assign parity_response_enable = cmd_reg[pcs_pkg::PAR_RESP_BIT];
	// The helper sees the next disable value, so the pin drops on the same edge
	// at which the disable bit sets and never stands while it reads one.
	assign irq.int_disable        = cmd_next[pcs_pkg::INT_DIS_BIT]; // R12 R13

	// Only the three enable bits this word relies on are writable.
	always_comb begin
		cmd_next = cmd_reg;
		if (hits(cfg_wr_en, cfg_offset, pcs_pkg::CMD_OFFSET)) begin
			cmd_next = (cmd_reg & ~(lane_mask(cfg_byte_en) & pcs_pkg::CMD_WR_MASK))
				| (cfg_wr_data & lane_mask(cfg_byte_en) & pcs_pkg::CMD_WR_MASK);
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			cmd_reg <= pcs_pkg::CMD_RESET;
		end else begin
			cmd_reg <= cmd_next;
		end
	end

	// ********************************************************
	// System error drive
	// ********************************************************

	// SERR goes out only for a request seen while enabled, so the flag cannot set otherwise.
	assign serr_fire = serr_request & system_error_enable; // R16

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			serr_reg <= 1'h0;
		end else begin
			serr_reg <= serr_fire; // R16
		end
	end

	// ********************************************************
	// Sticky flags
	// ********************************************************

	// Hardware set terms, one per flag position.
	always_comb begin
		flag_set                          = 16'h0000;
		flag_set[pcs_pkg::DET_PAR_BIT]  = addr_parity_err | data_parity_err; // R03
		flag_set[pcs_pkg::SIG_SERR_BIT] = serr_fire; // R04
		flag_set[pcs_pkg::RX_MABT_BIT]  = master_abort; // R05
		flag_set[pcs_pkg::RX_TABT_BIT]  = target_abort_rcvd; // R06
		flag_set[pcs_pkg::SIG_TABT_BIT] = target_abort_sent; // R07
		// All three conditions must meet in the same data phase.
		flag_set[pcs_pkg::MST_DPAR_BIT] = perr_seen & master_data_phase & parity_response_enable; // R09
	end

	// Write one clears within the flag mask; zeros and other bits do nothing.
	assign flag_clr = hits(cfg_wr_en, cfg_offset, pcs_pkg::STATUS_OFFSET)
		? (cfg_wr_data & lane_mask(cfg_byte_en) & pcs_pkg::FLAG_MASK) : 16'h0000; // R01 R15

	// The set term is applied after the clear, so a coincident event survives.
	// Software that clears in that cycle simply sees the flag again on its next read.
	assign flags_next = ((flags_reg & ~flag_clr) | flag_set) & pcs_pkg::FLAG_MASK; // R01 R17

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			flags_reg <= pcs_pkg::STATUS_RESET & pcs_pkg::FLAG_MASK; // R02
		end else begin
			flags_reg <= flags_next;
		end
	end

	assign detected_parity_flag       = flags_reg[pcs_pkg::DET_PAR_BIT];
	assign signaled_system_error_flag = flags_reg[pcs_pkg::SIG_SERR_BIT];
	assign received_master_abort_flag = flags_reg[pcs_pkg::RX_MABT_BIT];
	assign received_target_abort_flag = flags_reg[pcs_pkg::RX_TABT_BIT];
	assign signaled_target_abort_flag = flags_reg[pcs_pkg::SIG_TABT_BIT];
	assign master_data_parity_flag    = flags_reg[pcs_pkg::MST_DPAR_BIT];

	// ********************************************************
	// Interrupt helper
	// ********************************************************

	pcs_irq_gen u_irq (
		.clock       (clock),
		.arst_n      (arst_n),
		.int_cond    (int_cond),
		.int_cond_en (int_cond_en),
		.irq         (irq.gen)
	);

	// ********************************************************
	// Read path
	// ********************************************************

	// Constant bits cover medium decode, capability list and the zero fields.
	always_comb begin
		status_view = flags_reg | pcs_pkg::CONST_BITS; // R08 R10 R11 R15
		status_view[pcs_pkg::INT_STAT_BIT] = irq.int_pending; // R12
	end

	// Reads are registered and change no state, so polling is safe.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rd_data_reg  <= 16'h0000;
			rd_valid_reg <= 1'h0;
		end else begin
			rd_valid_reg <= cfg_rd_en;
			if (cfg_rd_en) begin
				unique case (cfg_offset)
					pcs_pkg::STATUS_OFFSET: rd_data_reg <= status_view; // R01 R02
					pcs_pkg::CMD_OFFSET:    rd_data_reg <= cmd_reg;
					default:                rd_data_reg <= 16'h0000;
				endcase
			end
		end
	end

	// ********************************************************
	// Outputs
	// ********************************************************
	assign cfg_rd_data   = rd_data_reg;
	assign cfg_rd_valid  = rd_valid_reg;
	assign serr_out      = serr_reg;
	assign intx_out      = irq.intx; // R12
	assign devsel_timing = devsel_reg; // R08

	// The decode timing code leaves through a flop like every other output,
	// which keeps the pin free of any combinational path.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			devsel_reg <= pcs_pkg::DEVSEL_MEDIUM; // R08
		end else begin
			devsel_reg <= pcs_pkg::DEVSEL_MEDIUM; // R08
		end
	end

	// ********************************************************
	// Checks
	// ********************************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);

	// Write-one-to-clear and side-effect-free reads.
	w1c_clear_a: assert property ((flag_clr[pcs_pkg::RX_MABT_BIT] && !master_abort)
		|=> !received_master_abort_flag) // R01
		else $error("Write one did not clear the master abort flag.");
	zero_write_a: assert property ((cfg_wr_en && flag_set == 16'h0000 && flag_clr == 16'h0000)
		|=> $stable(flags_reg)) // R01
		else $error("Flags changed without set or clear.");
	rd_quiet_a: assert property ((cfg_rd_en && !cfg_wr_en && flag_set == 16'h0000) |=> $stable(flags_reg)) // R01
		else $error("A read changed the sticky flags.");
	lane_off_a: assert property ((hits(cfg_wr_en, cfg_offset, pcs_pkg::STATUS_OFFSET) && !cfg_byte_en[1]
		&& flag_set == 16'h0000) |=> $stable(flags_reg)) // R01
		else $error("A write with the upper lane off changed the flags.");
	sticky_hold_a: assert property ((signaled_target_abort_flag && !flag_clr[pcs_pkg::SIG_TABT_BIT])
		|=> signaled_target_abort_flag) // R01
		else $error("Signaled target abort flag dropped without a clear.");
	set_wins_a: assert property ((master_abort && flag_clr[pcs_pkg::RX_MABT_BIT]) |=> received_master_abort_flag) // R17
		else $error("Clear beat a coincident set.");

	// Hardware events that set the sticky flags.
	parity_set_a: assert property ((addr_parity_err || data_parity_err) |=> detected_parity_flag) // R03
		else $error("Parity error did not set the detected flag.");
	serr_set_a: assert property ((serr_request && system_error_enable)
		|=> serr_out && signaled_system_error_flag) // R04
		else $error("Enabled system error was not driven and flagged.");
	serr_flag_a: assert property (signaled_system_error_flag && !$past(signaled_system_error_flag)
		|-> serr_out && $past(system_error_enable)) // R04
		else $error("System error flag set without enabled SERR.");
	received_master_abort_flag_set_a: assert property (master_abort |=> received_master_abort_flag) // R05
		else $error("Master abort did not set its flag.");
	tabort_set_a: assert property ((target_abort_rcvd || target_abort_sent) |=> received_target_abort_flag
		|| signaled_target_abort_flag) // R06
		else $error("Target abort event lost.");
	sig_tabort_a: assert property (target_abort_sent |=> signaled_target_abort_flag) // R07
		else $error("Signaled target abort did not set its flag.");
	dpar_set_a: assert property ((perr_seen && master_data_phase && parity_response_enable)
		|=> master_data_parity_flag) // R09
		else $error("Master data parity flag missed with all conditions met.");
	dpar_cause_a: assert property ($rose(master_data_parity_flag) |-> $past(perr_seen && master_data_phase
		&& parity_response_enable)) // R09
		else $error("Master data parity flag set without all conditions.");

	// Values returned by a status read.
	rd_status_a: assert property ((cfg_rd_en && cfg_offset == pcs_pkg::STATUS_OFFSET)
		|=> cfg_rd_valid && cfg_rd_data[15:4] == ($past(flags_reg[15:4]) | pcs_pkg::CONST_BITS[15:4])) // R02
		else $error("Status read returned a wrong value.");
	rd_low_bits_a: assert property ((cfg_rd_en && cfg_offset == pcs_pkg::STATUS_OFFSET)
		|=> cfg_rd_data[pcs_pkg::CAP_LIST_BIT] && cfg_rd_data[2:0] == 3'h0
		&& cfg_rd_data[pcs_pkg::INT_STAT_BIT] == $past(irq.int_pending)) // R11 R15
		else $error("Capability, pending or reserved read bits wrong.");
	const_bits_a: assert property (status_view[10:0] == {pcs_pkg::DEVSEL_MEDIUM, master_data_parity_flag,
		3'h0, 1'h1, irq.int_pending, 3'h0}) // R10
		else $error("Constant status bits wrong.");
	devsel_match_a: assert property (devsel_timing == status_view[pcs_pkg::DEVSEL_LSB +: 2]) // R08
		else $error("Decode timing pins disagree with the status word.");

	// Enables and pin drives.
	serr_gate_a: assert property (!system_error_enable |=> !serr_out) // R16
		else $error("SERR driven while disabled.");
	serr_no_flag_a: assert property (!system_error_enable |=> !$rose(signaled_system_error_flag)) // R16
		else $error("System error flag set while SERR was disabled.");
	intx_pin_a: assert property (intx_out
		|-> status_view[pcs_pkg::INT_STAT_BIT] && !cmd_reg[pcs_pkg::INT_DIS_BIT]) // R12
		else $error("INTx driven while disabled or nothing pending.");

	cover_w1c_c:  cover property (received_master_abort_flag ##1 flag_clr[pcs_pkg::RX_MABT_BIT] ##1 1'h1);
	cover_race_c: cover property (target_abort_sent && flag_clr[pcs_pkg::SIG_TABT_BIT]);
	cover_dpar_c: cover property ($rose(master_data_parity_flag));
	cover_intx_c: cover property ($rose(intx_out));

endmodule

// ==== tb/pcs_bus_agent.sv ====
// Far-side bus agent model: drives the event strobes seen by the status word.
// Assumes the bench calls pulse and that strobes change at falling clock edges.
`timescale 1ns/1ps
module pcs_bus_agent (
	// Clock
	input  wire logic       clock,
	// Event strobes toward the device
	output logic      [7:0] ev
);
	// Strobes rest low from time zero so no false event lands during reset.
	initial begin
		ev = 8'h00;
	end

	// One-cycle pulse; a longer one would just set the same sticky flag again.
	task automatic pulse(input logic [7:0] m);
		@(negedge clock);
		ev = m;
		@(negedge clock);
		ev = 8'h00;
	endtask
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the configuration status word.
// Assumes the bus agent model drives the event strobes; the bench drives the rest.
`timescale 1ns/1ps
module testbench;
	logic        clock;
	logic        arst_n;
	logic        rd_en;
	logic        wr_en;
	logic [7:0]  offset;
	logic [1:0]  be;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic        rvalid;
	logic [7:0]  ev;
	logic [3:0]  cond;
	logic [3:0]  cond_en;
	logic        serr_out;
	logic        intx_out;
	logic [1:0]  devsel;
	int          error_cnt;
	int          checks_done;
	localparam logic [7:0] ST  = pcs_pkg::STATUS_OFFSET;
	localparam logic [7:0] CMD = pcs_pkg::CMD_OFFSET;

	pcs_bus_agent agent (.clock(clock), .ev(ev));
	pcs_status_word dut (
		.clock(clock), .arst_n(arst_n), .cfg_rd_en(rd_en), .cfg_wr_en(wr_en),
		.cfg_offset(offset), .cfg_byte_en(be), .cfg_wr_data(wdata),
		.cfg_rd_data(rdata), .cfg_rd_valid(rvalid), .addr_parity_err(ev[0]),
		.data_parity_err(ev[1]), .serr_request(ev[2]), .master_abort(ev[3]),
		.target_abort_rcvd(ev[4]), .target_abort_sent(ev[5]), .perr_seen(ev[6]),
		.master_data_phase(ev[7]), .int_cond(cond), .int_cond_en(cond_en),
		.serr_out(serr_out), .intx_out(intx_out), .devsel_timing(devsel)
	);

	// Half period of 2.5 ns gives the 200 MHz clock.
	initial begin
		clock = 1'h0;
		forever #2.5 clock = ~clock;
	end

	// Case equality so that an unknown never passes as a match.
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask

	// Read is sampled one cycle after the request, while the valid pulse stands.
	task automatic rd(input logic [7:0] off, input logic [15:0] exp);
		@(negedge clock);
		rd_en = 1'h1;
		offset = off;
		@(negedge clock);
		rd_en = 1'h0;
		chk({15'h0000, rvalid}, 16'h0001, "read valid");
		chk(rdata, exp, "read data");
	endtask

	task automatic wr(input logic [7:0] off, input logic [1:0] lanes, input logic [15:0] d);
		@(negedge clock);
		wr_en = 1'h1;
		offset = off;
		be = lanes;
		wdata = d;
		@(negedge clock);
		wr_en = 1'h0;
	endtask

	// Reset value, constant fields and an unmapped offset.
	task automatic t_reset();
		rd(ST, 16'h0210);
		rd(CMD, 16'h0000);
		chk({14'h0000, devsel}, 16'h0001, "decode timing");
		rd(8'h08, 16'h0000);
		wr(ST, 2'h3, 16'h06FF);
		rd(ST, 16'h0210);
		$display("test reset done");
	endtask

	// Flags at bits 15, 13, 12 and 11: set by their events, kept by zeros and disabled lanes, cleared by a one.
	task automatic t_flags();
		logic [7:0]  m [5] = '{8'h01, 8'h02, 8'h08, 8'h10, 8'h20};
		int          b [5] = '{15, 15, 13, 12, 11};
		logic [15:0] f;
		for (int i = 0; i < 5; i++) begin
			f = 16'h0001 << b[i];
			agent.pulse(m[i]);
			rd(ST, 16'h0210 | f);
			wr(ST, 2'h3, ~f);
			wr(ST, 2'h1, 16'hFFFF);
			rd(ST, 16'h0210 | f);
			wr(ST, 2'h3, f);
			rd(ST, 16'h0210);
		end
		$display("test flags done");
	endtask

	// System error drive and flag only while its enable is set.
	task automatic t_serr();
		agent.pulse(8'h04);
		chk({15'h0000, serr_out}, 16'h0000, "serr gated");
		rd(ST, 16'h0210);
		wr(CMD, 2'h3, 16'h0100);
		agent.pulse(8'h04);
		chk({15'h0000, serr_out}, 16'h0001, "serr drive");
		rd(ST, 16'h4210);
		wr(ST, 2'h3, 16'h4000);
		wr(CMD, 2'h3, 16'h0000);
		$display("test serr done");
	endtask

	// Master data parity flag needs all three conditions at once.
	task automatic t_dpar();
		for (int k = 0; k < 8; k++) begin
			wr(CMD, 2'h3, k[2] ? 16'h0040 : 16'h0000);
			agent.pulse({k[1], k[0], 6'h00});
			rd(ST, (k == 7) ? 16'h0310 : 16'h0210);
			wr(ST, 2'h3, 16'h0100);
		end
		$display("test dpar done");
	endtask

	// Pending bit follows enabled conditions only; disable gates only the pin.
	task automatic t_irq();
		@(negedge clock);
		cond = 4'h5;
		cond_en = 4'hA;
		rd(ST, 16'h0210);
		chk({15'h0000, intx_out}, 16'h0000, "intx idle");
		cond_en = 4'h4;
		rd(ST, 16'h0218);
		chk({15'h0000, intx_out}, 16'h0001, "intx on");
		wr(CMD, 2'h3, 16'h0400);
		rd(ST, 16'h0218);
		chk({15'h0000, intx_out}, 16'h0000, "intx off");
		wr(ST, 2'h3, 16'h0008);
		rd(ST, 16'h0218);
		cond = 4'h0;
		wr(CMD, 2'h3, 16'h0000);
		$display("test irq done");
	endtask

	// Event and clearing write on the same edge: the event must survive.
	task automatic t_race();
		fork
			agent.pulse(8'h08);
			wr(ST, 2'h3, 16'h2000);
		join
		rd(ST, 16'h2210);
		wr(ST, 2'h3, 16'h2000);
		rd(ST, 16'h0210);
		$display("test race done");
	endtask

	// Reset in mid-run: flags, enables, read data and the SERR output drop at once.
	task automatic t_rerun();
		wr(CMD, 2'h3, 16'h0100);
		agent.pulse(8'h14);
		chk({15'h0000, serr_out}, 16'h0001, "serr before reset");
		arst_n = 1'h0;
		@(negedge clock);
		chk(rdata, 16'h0000, "read data in reset");
		chk({15'h0000, serr_out}, 16'h0000, "serr in reset");
		arst_n = 1'h1;
		rd(ST, 16'h0210);
		rd(CMD, 16'h0000);
		$display("test rerun done");
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Main sequence: inputs settle at time zero, reset held three cycles.
	initial begin
		error_cnt = 0;
		checks_done = 0;
		arst_n = 1'h0;
		rd_en = 1'h0;
		wr_en = 1'h0;
		offset = 8'h00;
		be = 2'h0;
		wdata = 16'h0000;
		cond = 4'h0;
		cond_en = 4'h0;
		repeat (3) @(posedge clock);
		@(negedge clock);
		arst_n = 1'h1;
		t_reset();
		t_flags();
		t_serr();
		t_dpar();
		t_irq();
		t_race();
		t_rerun();
		print_verdict();
	end

	// The tests need well under a thousand cycles; this cuts a hang short.
	initial begin
		#20000;
		error_cnt++;
		$display("unexpected at %0t: watchdog expired", $time);
		print_verdict();
	end
endmodule
